//--- shared/plut_consts.svh
`ifndef PLUT_CONSTS_SVH
`define PLUT_CONSTS_SVH
// Behaviour
// - a 256 by 18-bit colour table, read by pixels, read and written by host
// - masked 8-bit index reads the table; entry splits into three 6-bit fields
// - index and blank sampled each edge; result at DAC after three more edges
// - blank is delayed by the same depth as the pixel data
// - blank low forces zero into all three DAC inputs
// - select 00 address write mode, 11 read mode, 01 colour, 10 mask
// - 8-bit two-way host bus; table reached only via address and colour
// - after address write, red green blue writes store entry then increment address
// - read-mode address write loads staging from table then increments address
// - colour reads return red green blue; after blue reload staging and increment
// - any address update abandons a partial colour sequence, restarts at red
// - host transfers and mask updates are synchronised into the pixel clock
// - pixel table address is pixel index ANDed with the mask register
// - mask writes leave address, staging and colour sequence untouched
// - colour writes keep low six bits; reads return upper two bits zero
// - a read at select 00 returns the address like select 11
// - the mask never applies to host table addresses
// - select taken at strobe fall, write data at write rise; never both strobes

`define PLUT_IDX_W 8
`define PLUT_COL_W 6
`define PLUT_ENTRY_W 18
`define PLUT_TABLE_DEPTH 256
`define PLUT_SEL_ADDR_WR 2'h0
`define PLUT_SEL_COLOUR 2'h1
`define PLUT_SEL_MASK 2'h2
`define PLUT_SEL_ADDR_RD 2'h3
`define PLUT_RED_LSB 12
`define PLUT_GREEN_LSB 6
`define PLUT_BLUE_LSB 0
`define PLUT_MASK_RST 8'hFF
`define PLUT_ADDR_RST 8'h00
`define PLUT_BYTE_RST 8'h00
`define PLUT_ENTRY_RST 18'h0_0000
`define PLUT_DAC_ZERO 6'h00
`define PLUT_SYNC_W 12
`define PLUT_SYNC_RST 12'hC00
`define PLUT_FIFO_DEPTH 8
`define PLUT_FIFO_W 26
`endif

//--- shared/plut_pkg.sv
`default_nettype none
package plut_pkg;
   // byte position inside a three-byte colour transfer
   typedef enum logic [1:0] {
      SEQ_RED,
      SEQ_GREEN,
      SEQ_BLUE
   } plut_seq_t;
endpackage : plut_pkg
`default_nettype wire

//--- hw/plut_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module plut_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] store_r [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // honest flags straight from the fill count
   assign in_ready_o = (count_r != (AW + 1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o = store_r[rd_ptr_r];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // storage needs no reset, the count guards it
   always_ff @(posedge clk_i) begin
      if (push) begin
         store_r[wr_ptr_r] <= in_data_i;
      end
   end

   // pointers wrap at depth, not only at powers of two
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // fill level
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_r <= '0;
      end else if (push & ~pop) begin
         count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
         count_r <= count_r - 1'b1;
      end
   end
endmodule : plut_fifo
`default_nettype wire

//--- hw/plut_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "plut_consts.svh"
module plut_top #(
   parameter int FIFO_DEPTH = `PLUT_FIFO_DEPTH
) (
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   input wire logic [`PLUT_IDX_W-1:0] PIXEL_INDEX_INPUTS_I,
   input wire logic BLANK_N_I,
   output logic [`PLUT_COL_W-1:0] RED_O,
   output logic [`PLUT_COL_W-1:0] GREEN_O,
   output logic [`PLUT_COL_W-1:0] BLUE_O,
   input wire logic HOST_RD_N_I,
   input wire logic HOST_WR_N_I,
   input wire logic REGISTER_SELECT_LOW_I,
   input wire logic REGISTER_SELECT_HIGH_I,
   input wire logic [`PLUT_IDX_W-1:0] HOST_DATA_BUS_I,
   output logic [`PLUT_IDX_W-1:0] HOST_DATA_BUS_O,
   output logic HOST_DATA_BUS_OE_O
);
   localparam int EW = `PLUT_ENTRY_W;
   localparam int CW = `PLUT_COL_W;
   localparam int AW = `PLUT_IDX_W;

   // host pin synchroniser chain
   logic [`PLUT_SYNC_W-1:0] host_raw;
   logic [`PLUT_SYNC_W-1:0] meta_r;
   logic [`PLUT_SYNC_W-1:0] sync2_r;
   logic [`PLUT_SYNC_W-1:0] sync3_r;
   logic [`PLUT_SYNC_W-1:0] host_r;
   logic [`PLUT_SYNC_W-1:0] settled;

   // decoded host view
   logic rd_n;
   logic wr_n;
   logic [1:0] sel;
   logic [AW-1:0] dat;
   logic rd_prev_r;
   logic wr_prev_r;
   logic rd_fall;
   logic rd_rise;
   logic wr_fall;
   logic wr_rise;
   logic [1:0] sel_r;

   // host register state
   logic [AW-1:0] addr_r;
   logic [AW-1:0] mask_r;
   logic [EW-1:0] stage_r;
   plut_pkg::plut_seq_t seq_r;
   logic commit_pend_r;
   logic load_pend_r;
   logic oe_r;
   logic [AW-1:0] rdata_r;

   // events
   logic addr_wr_ev;
   logic col_wr_ev;
   logic col_rd_ev;
   logic last_byte;
   logic push_done;
   logic load_go;
   logic drain;
   logic [CW-1:0] field_now;

   // write queue
   logic q_in_ready;
   logic q_out_valid;
   logic q_out_ready;
   logic [`PLUT_FIFO_W-1:0] q_out_data;

   // colour table and pixel pipeline
   logic [EW-1:0] table_mem [0:`PLUT_TABLE_DEPTH-1];
   logic [EW-1:0] host_entry;
   logic [AW-1:0] idx_r;
   logic blank1_r;
   logic blank2_r;
   logic blank3_r;
   logic [EW-1:0] entry_r;
   logic [EW-1:0] entry2_r;

   assign host_raw = {HOST_RD_N_I, HOST_WR_N_I, REGISTER_SELECT_HIGH_I,
                      REGISTER_SELECT_LOW_I, HOST_DATA_BUS_I};

   // a bit only moves once stages two and three agree
   assign settled = (sync2_r & ~(sync2_r ^ sync3_r)) | (host_r & (sync2_r ^ sync3_r));

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         meta_r <= `PLUT_SYNC_RST;
         sync2_r <= `PLUT_SYNC_RST;
         sync3_r <= `PLUT_SYNC_RST;
         host_r <= `PLUT_SYNC_RST;
      end else begin
         meta_r <= host_raw;
         sync2_r <= meta_r;
         sync3_r <= sync2_r;
         host_r <= settled;
      end
   end

   assign rd_n = host_r[11];
   assign wr_n = host_r[10];
   assign sel = host_r[9:8];
   assign dat = host_r[7:0];

   // strobe edges, seen after the filter
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rd_prev_r <= 1'b1;
         wr_prev_r <= 1'b1;
      end else begin
         rd_prev_r <= rd_n;
         wr_prev_r <= wr_n;
      end
   end

   assign rd_fall = rd_prev_r & ~rd_n;
   assign rd_rise = ~rd_prev_r & rd_n;
   assign wr_fall = wr_prev_r & ~wr_n;
   assign wr_rise = ~wr_prev_r & wr_n;

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         sel_r <= `PLUT_SEL_ADDR_WR;
      end else if (rd_fall | wr_fall) begin
         sel_r <= sel;
      end
   end

   assign addr_wr_ev = wr_rise & ((sel_r == `PLUT_SEL_ADDR_WR) | (sel_r == `PLUT_SEL_ADDR_RD));
   assign col_wr_ev = wr_rise & (sel_r == `PLUT_SEL_COLOUR);
   assign col_rd_ev = rd_rise & (sel_r == `PLUT_SEL_COLOUR);
   assign last_byte = (seq_r == plut_pkg::SEQ_BLUE);
   assign push_done = commit_pend_r & q_in_ready;
   // reads wait for queued writes so read-back sees them
   assign load_go = load_pend_r & ~q_out_valid;
   // host port uses the raw address, no mask
   assign host_entry = table_mem[addr_r];

   // mask has its own write path
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         mask_r <= `PLUT_MASK_RST;
      end else if (wr_rise & (sel_r == `PLUT_SEL_MASK)) begin
         mask_r <= dat;
      end
   end

   // address counter wraps in 8 bits
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         addr_r <= `PLUT_ADDR_RST;
      end else if (addr_wr_ev) begin
         addr_r <= dat;
      end else if (push_done | load_go) begin
         addr_r <= addr_r + 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         seq_r <= plut_pkg::SEQ_RED;
      end else if (addr_wr_ev) begin
         seq_r <= plut_pkg::SEQ_RED;
      end else if (col_wr_ev | col_rd_ev) begin
         case (seq_r)
            plut_pkg::SEQ_RED: begin
               seq_r <= plut_pkg::SEQ_GREEN;
            end
            plut_pkg::SEQ_GREEN: begin
               seq_r <= plut_pkg::SEQ_BLUE;
            end
            default: begin
               seq_r <= plut_pkg::SEQ_RED;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         commit_pend_r <= 1'b0;
      end else if (addr_wr_ev) begin
         commit_pend_r <= 1'b0;
      end else if (col_wr_ev & last_byte) begin
         commit_pend_r <= 1'b1;
      end else if (push_done) begin
         commit_pend_r <= 1'b0;
      end
   end

   // read-mode address write asks for a load
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         load_pend_r <= 1'b0;
      end else if (addr_wr_ev) begin
         load_pend_r <= (sel_r == `PLUT_SEL_ADDR_RD);
      end else if (col_rd_ev & last_byte) begin
         load_pend_r <= 1'b1;
      end else if (load_go) begin
         load_pend_r <= 1'b0;
      end
   end

   // staging keeps six bits per colour
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         stage_r <= `PLUT_ENTRY_RST;
      end else if (load_go) begin
         stage_r <= host_entry;
      end else if (col_wr_ev) begin
         case (seq_r)
            plut_pkg::SEQ_RED: begin
               stage_r[`PLUT_RED_LSB +: CW] <= dat[CW-1:0];
            end
            plut_pkg::SEQ_GREEN: begin
               stage_r[`PLUT_GREEN_LSB +: CW] <= dat[CW-1:0];
            end
            default: begin
               stage_r[`PLUT_BLUE_LSB +: CW] <= dat[CW-1:0];
            end
         endcase
      end
   end

   // colour byte that the next read returns
   always_comb begin
      case (seq_r)
         plut_pkg::SEQ_RED: begin
            field_now = stage_r[`PLUT_RED_LSB +: CW];
         end
         plut_pkg::SEQ_GREEN: begin
            field_now = stage_r[`PLUT_GREEN_LSB +: CW];
         end
         default: begin
            field_now = stage_r[`PLUT_BLUE_LSB +: CW];
         end
      endcase
   end

   // read data captured at read fall
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rdata_r <= `PLUT_BYTE_RST;
      end else if (rd_fall) begin
         case (sel)
            `PLUT_SEL_ADDR_WR, `PLUT_SEL_ADDR_RD: begin
               rdata_r <= addr_r;
            end
            `PLUT_SEL_COLOUR: begin
               rdata_r <= {2'h0, field_now};
            end
            `PLUT_SEL_MASK: begin
               rdata_r <= mask_r;
            end
            default: begin
               rdata_r <= `PLUT_BYTE_RST;
            end
         endcase
      end
   end

   // drive the bus only while read is low
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         oe_r <= 1'b0;
      end else if (rd_fall) begin
         oe_r <= 1'b1;
      end else if (rd_rise) begin
         oe_r <= 1'b0;
      end
   end

   assign HOST_DATA_BUS_O = rdata_r;
   assign HOST_DATA_BUS_OE_O = oe_r;

   // writes drain during blanking to keep visible pixels clean;
   // a full queue or a waiting read-back forces them through
   assign q_out_ready = ~blank1_r | ~q_in_ready | load_pend_r;
   assign drain = q_out_valid & q_out_ready;

   plut_fifo #(
      .WIDTH(`PLUT_FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_write_queue (
      .clk_i(CLK_SYS_I),
      .reset_n_i(RESET_N_I),
      .in_valid_i(commit_pend_r),
      .in_ready_o(q_in_ready),
      .in_data_i({addr_r, stage_r}),
      .out_valid_o(q_out_valid),
      .out_ready_i(q_out_ready),
      .out_data_o(q_out_data)
   );

   always_ff @(posedge CLK_SYS_I) begin
      if (drain) begin
         table_mem[q_out_data[EW +: AW]] <= q_out_data[EW-1:0];
      end
   end

   // pipeline, stage one samples the inputs
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         idx_r <= `PLUT_BYTE_RST;
         blank1_r <= 1'b0;
      end else begin
         idx_r <= PIXEL_INDEX_INPUTS_I;
         blank1_r <= BLANK_N_I;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         entry_r <= `PLUT_ENTRY_RST;
         entry2_r <= `PLUT_ENTRY_RST;
         blank2_r <= 1'b0;
         blank3_r <= 1'b0;
      end else begin
         entry_r <= table_mem[idx_r & mask_r];
         entry2_r <= entry_r;
         blank2_r <= blank1_r;
         blank3_r <= blank2_r;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RED_O <= `PLUT_DAC_ZERO;
         GREEN_O <= `PLUT_DAC_ZERO;
         BLUE_O <= `PLUT_DAC_ZERO;
      end else if (!blank3_r) begin
         RED_O <= `PLUT_DAC_ZERO;
         GREEN_O <= `PLUT_DAC_ZERO;
         BLUE_O <= `PLUT_DAC_ZERO;
      end else begin
         RED_O <= entry2_r[`PLUT_RED_LSB +: CW];
         GREEN_O <= entry2_r[`PLUT_GREEN_LSB +: CW];
         BLUE_O <= entry2_r[`PLUT_BLUE_LSB +: CW];
      end
   end

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESET_N_I);

   sequence s_rd_addr_write;
      wr_rise && (sel_r == `PLUT_SEL_ADDR_RD);
   endsequence

   sequence s_load_done;
      load_pend_r ##[0:12] load_go;
   endsequence

   blank_zero_a : assert property (
      !$past(BLANK_N_I, 4) |-> (RED_O == 6'h00) && (GREEN_O == 6'h00) && (BLUE_O == 6'h00))
      else $error("blanked pixel reached the DAC");

   dac_split_a : assert property (
      $past(BLANK_N_I, 4) |-> {RED_O, GREEN_O, BLUE_O} == $past(entry_r, 2))
      else $error("DAC fields not aligned with lookup");

   // visible pixels only: words never written read back unknown
   mask_and_a : assert property (
      blank2_r && !$past(drain) |-> entry_r == table_mem[$past(idx_r & mask_r)])
      else $error("pixel lookup not masked");

   read_load_a : assert property (
      s_rd_addr_write |=> s_load_done)
      else $error("read-mode address write did not load staging");

   load_copy_a : assert property (
      load_go |=> (stage_r == $past(host_entry)) && (addr_r == $past(addr_r) + 8'h01))
      else $error("staging reload or increment wrong");

   commit_inc_a : assert property (
      col_wr_ev && last_byte |=> commit_pend_r ##[0:3] push_done ##1 !commit_pend_r)
      else $error("blue write not committed");

   seq_restart_a : assert property (
      addr_wr_ev |=> (seq_r == plut_pkg::SEQ_RED) && !commit_pend_r)
      else $error("address update kept partial sequence");

   mask_indep_a : assert property (
      wr_rise && (sel_r == `PLUT_SEL_MASK) && !load_go && !push_done
      |=> $stable(addr_r) && $stable(seq_r) && $stable(stage_r))
      else $error("mask write disturbed host registers");

   colour_read_a : assert property (
      rd_fall && (sel == `PLUT_SEL_COLOUR) |=> HOST_DATA_BUS_O[7:6] == 2'h0)
      else $error("colour read upper bits not zero");

   addr_alias_a : assert property (
      rd_fall && (sel == `PLUT_SEL_ADDR_WR) |=> HOST_DATA_BUS_O == $past(addr_r))
      else $error("select 00 read not the address");
endmodule : plut_top
`default_nettype wire

//--- verification/plut_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module plut_host_model (
   input wire logic clk_i,
   output logic host_rd_n_o,
   output logic host_wr_n_o,
   output logic sel_low_o,
   output logic sel_high_o,
   output logic [7:0] bus_to_dev_o,
   input wire logic [7:0] bus_from_dev_i,
   input wire logic bus_oe_i
);
   logic drv;
   logic [7:0] val;
   logic float_v;
   initial begin
      host_rd_n_o = 1'b1;
      host_wr_n_o = 1'b1;
      {sel_high_o, sel_low_o} = 2'h0;
      drv = 1'b0;
      val = 8'h00;
      float_v = 1'b0;
   end
   // released wire shows a toggling pattern, never a held value
   always @(posedge clk_i) float_v <= ~float_v;
   assign bus_to_dev_o = bus_oe_i ? bus_from_dev_i : (drv ? val : {8{float_v}});
   // one strobe at a time, long gaps
   task automatic host_wr(input logic [1:0] sel, input logic [7:0] d);
      @(posedge clk_i);
      #10 {sel_high_o, sel_low_o} = sel;
      drv = 1'b1;
      val = d;
      repeat (2) @(posedge clk_i);
      #10 host_wr_n_o = 1'b0;
      repeat (8) @(posedge clk_i);
      #10 host_wr_n_o = 1'b1;
      // data held well past the rise: the sync delays its capture
      repeat (8) @(posedge clk_i);
      #10 drv = 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : host_wr
   // read strobe alone, data taken while low
   task automatic host_rd(input logic [1:0] sel, output logic [7:0] d, output logic oe);
      @(posedge clk_i);
      #10 {sel_high_o, sel_low_o} = sel;
      repeat (2) @(posedge clk_i);
      #10 host_rd_n_o = 1'b0;
      repeat (9) @(posedge clk_i);
      d = bus_to_dev_o;
      oe = bus_oe_i;
      #10 host_rd_n_o = 1'b1;
      repeat (14) @(posedge clk_i);
   endtask : host_rd
endmodule : plut_host_model
`default_nettype wire

//--- verification/plut_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "plut_consts.svh"
module plut_top_bench;
   logic clk_sys, reset_n, blank_n, rd_n, wr_n, sel_lo, sel_hi, oe, rd_oe;
   logic [7:0] pix_idx, bus_to_dev, bus_from_dev, rd_v, exp_addr;
   logic [5:0] red, green, blue;
   logic [17:0] ref_tab [256];
   logic [7:0] idx_a [6];
   int err_total, n_compared, cycles;
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
$display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
   plut_top #(.FIFO_DEPTH(`PLUT_FIFO_DEPTH)) plut_top_inst (
      .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .PIXEL_INDEX_INPUTS_I(pix_idx),
      .BLANK_N_I(blank_n), .RED_O(red), .GREEN_O(green), .BLUE_O(blue),
      .HOST_RD_N_I(rd_n), .HOST_WR_N_I(wr_n), .REGISTER_SELECT_LOW_I(sel_lo),
      .REGISTER_SELECT_HIGH_I(sel_hi), .HOST_DATA_BUS_I(bus_to_dev),
      .HOST_DATA_BUS_O(bus_from_dev), .HOST_DATA_BUS_OE_O(oe));
   plut_host_model plut_host_model_inst (
      .clk_i(clk_sys), .host_rd_n_o(rd_n), .host_wr_n_o(wr_n), .sel_low_o(sel_lo),
      .sel_high_o(sel_hi), .bus_to_dev_o(bus_to_dev), .bus_from_dev_i(bus_from_dev),
      .bus_oe_i(oe));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // hang guard, far above the roughly 1700 cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      plut_host_model_inst.host_wr(s, d);
   endtask : wr
   task automatic rd_chk(input logic [1:0] s, input logic [7:0] e);
      plut_host_model_inst.host_rd(s, rd_v, rd_oe);
      `CHK("host read data", e, rd_v)
      `CHK("host bus enable", 1'b1, rd_oe)
   endtask : rd_chk
   // three colour bytes, only the low six kept
   task automatic wr_col(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
      wr(`PLUT_SEL_COLOUR, r);
      wr(`PLUT_SEL_COLOUR, g);
      wr(`PLUT_SEL_COLOUR, b);
      ref_tab[exp_addr] = {r[5:0], g[5:0], b[5:0]};
      exp_addr = exp_addr + 8'h01;
   endtask : wr_col
   task automatic col_chk(input logic [7:0] a);
      rd_chk(`PLUT_SEL_COLOUR, {2'b00, ref_tab[a][17:12]});
      rd_chk(`PLUT_SEL_COLOUR, {2'b00, ref_tab[a][11:6]});
      rd_chk(`PLUT_SEL_COLOUR, {2'b00, ref_tab[a][5:0]});
   endtask : col_chk
   // pixel i shows exactly four drive slots later; slot 3 is blanked
   task automatic stream(input logic [7:0] msk);
      logic [17:0] e;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         #10;
         if (i >= 4) begin
            e = (i == 7) ? 18'h0_0000 : ref_tab[idx_a[i-4] & msk];
            `CHK("red", e[17:12], red)
            `CHK("green", e[11:6], green)
            `CHK("blue", e[5:0], blue)
         end
         pix_idx = (i < 6) ? idx_a[i] : 8'h00;
         blank_n = (i < 6) && (i != 3);
      end
   endtask : stream
   initial begin
      reset_n = 1'b0;
      blank_n = 1'b0;
      pix_idx = 8'h00;
      err_total = 0;
      n_compared = 0;
      repeat (8) @(posedge clk_sys);
      #10 reset_n = 1'b1;
      `CHK("red at reset", 6'h00, red)
      `CHK("bus enable idle", 1'b0, oe)
      // register reset values
      rd_chk(`PLUT_SEL_ADDR_WR, `PLUT_ADDR_RST);
      rd_chk(`PLUT_SEL_MASK, `PLUT_MASK_RST);
      // consecutive writes across the wrap point; every word a reload reaches is written
      wr(`PLUT_SEL_ADDR_WR, 8'hFE);
      exp_addr = 8'hFE;
      wr_col(8'hFF, 8'h42, 8'h83);
      wr_col(8'h15, 8'hEA, 8'h3F);
      wr_col(8'h2A, 8'h01, 8'hD0);
      wr_col(8'h11, 8'h22, 8'h33);
      rd_chk(`PLUT_SEL_ADDR_RD, 8'h02);
      // partial write abandoned by a new address
      wr(`PLUT_SEL_ADDR_WR, 8'h10);
      wr(`PLUT_SEL_COLOUR, 8'h33);
      wr(`PLUT_SEL_COLOUR, 8'h34);
      wr(`PLUT_SEL_ADDR_WR, 8'h10);
      exp_addr = 8'h10;
      wr_col(8'h05, 8'h06, 8'h07);
      wr_col(8'h3C, 8'h0D, 8'hE8);
      // mask write inside a colour sequence
      wr(`PLUT_SEL_ADDR_WR, 8'h20);
      wr(`PLUT_SEL_COLOUR, 8'h09);
      wr(`PLUT_SEL_MASK, 8'h1F);
      wr(`PLUT_SEL_COLOUR, 8'h0A);
      wr(`PLUT_SEL_COLOUR, 8'h0B);
      ref_tab[8'h20] = {6'h09, 6'h0A, 6'h0B};
      rd_chk(`PLUT_SEL_ADDR_WR, 8'h21);
      rd_chk(`PLUT_SEL_MASK, 8'h1F);
      // visible pixels keep these writes queued until the read-back forces them out
      #10 blank_n = 1'b1;
      exp_addr = 8'h21;
      wr_col(8'h21, 8'h12, 8'h7F);
      wr_col(8'h30, 8'h2F, 8'h04);
      // read back across the wrap
      wr(`PLUT_SEL_ADDR_RD, 8'hFE);
      #10 blank_n = 1'b0;
      rd_chk(`PLUT_SEL_ADDR_RD, 8'hFF);
      col_chk(8'hFE);
      col_chk(8'hFF);
      col_chk(8'h00);
      rd_chk(`PLUT_SEL_ADDR_WR, 8'h02);
      rd_chk(`PLUT_SEL_ADDR_RD, 8'h02);
      // host addresses ignore the mask of 1F
      wr(`PLUT_SEL_ADDR_RD, 8'h20);
      col_chk(8'h20);
      col_chk(8'h21);
      // partial read abandoned, restarts at red
      wr(`PLUT_SEL_ADDR_RD, 8'hFE);
      rd_chk(`PLUT_SEL_COLOUR, {2'b00, ref_tab[8'hFE][17:12]});
      wr(`PLUT_SEL_ADDR_RD, 8'h10);
      col_chk(8'h10);
      // pixel path with mask 1F, then with all bits
      idx_a = '{8'h30, 8'h20, 8'hF0, 8'h30, 8'h20, 8'hF0};
      stream(8'h1F);
      wr(`PLUT_SEL_MASK, 8'hFF);
      idx_a = '{8'hFE, 8'hFF, 8'h00, 8'h10, 8'h20, 8'hFE};
      stream(8'hFF);
      complete_run();
   end
endmodule : plut_top_bench
`default_nettype wire
